// ---- rtl/fsw_top.sv ----
`timescale 1ns/10ps
`include "fsw_defs.svh"
module fsw_top
   import fsw_pkg::*;
#(
   parameter int N_TTL       = 9,
   parameter int N_ISO       = 4,
   parameter int TICK_CYCLES = `FSW_TICK_CYCLES
) (
   input  wire logic                 mclk,
   input  wire logic                 rst,
   input  wire logic                 shd_enable,
   input  wire logic                 shd_input,
   input  wire logic                 wd_arm,
   input  wire logic                 wd_disarm,
   input  wire logic                 wd_service,
   input  wire logic [15:0]          wd_timeout,
   input  wire logic [1:0]           wd_action,
   input  wire logic [2*N_TTL-1:0]   ttl_safe,
   input  wire logic [N_ISO-1:0]     iso_safe,
   input  wire logic [N_TTL-1:0]     ttl_norm,
   input  wire logic [N_TTL-1:0]     ttl_norm_oe_n,
   input  wire logic [N_ISO-1:0]     iso_norm,
   output logic [N_TTL-1:0]          ttl_out,
   output logic [N_TTL-1:0]          ttl_oe_n,
   output logic [N_ISO-1:0]          iso_out,
   output logic                      wd_flag,
   output logic                      wd_ttl_out,
   output logic                      halt,
   output logic                      fault,
   output logic                      ext_shd_seen,
   output logic                      wd_expired_out
);
   // ************************************************************
   // millisecond tick
   // ************************************************************
   fsw_tick_if tk ();
   fsw_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
      .mclk (mclk),
      .rst  (rst),
      .tk   (tk)
   );

   fsw_wd_e     st_reg;
   logic [15:0] ms_reg;
   fsw_act_t    act_reg;
   logic        shd_in_d_reg;
   logic        ext_reg;
   logic        wdf_reg;
   logic        flt_reg;

   assign tk.clr = (st_reg != FSW_ARMED) || wd_service;

   function automatic logic [15:0] fsw_limit(input logic [15:0] t);
      // zero means shortest step, clamp to the maximum
      if (t == 16'h0000)
         return 16'h0001;
      else if (t > `FSW_TIMEOUT_MAX)
         return `FSW_TIMEOUT_MAX;
      else
         return t;
   endfunction

   // ************************************************************
   // watchdog state
   // ************************************************************
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_reg  <= FSW_IDLE;
         ms_reg  <= 16'h0000;
         act_reg <= `FSW_ACT_IND;
      end else begin
         case (st_reg)
            FSW_IDLE: begin
               ms_reg <= 16'h0000;
               if (wd_arm) begin
                  st_reg  <= FSW_ARMED;
                  act_reg <= wd_action;
               end
            end
            FSW_ARMED: begin
               if (wd_disarm) begin
                  st_reg <= FSW_IDLE;
                  ms_reg <= 16'h0000;
               end else if (wd_service) begin
                  ms_reg <= 16'h0000;
               end else if (tk.tick) begin
                  if (ms_reg + 16'h0001 >= fsw_limit(wd_timeout)) begin
                     st_reg <= FSW_EXPIRED;
                  end
                  ms_reg <= ms_reg + 16'h0001;
               end
            end
            FSW_EXPIRED: begin
               // expiry holds until disarm; service cannot revive it
               if (wd_disarm) begin
                  st_reg <= FSW_IDLE;
                  ms_reg <= 16'h0000;
               end
            end
            default: st_reg <= FSW_IDLE;
         endcase
      end
   end

   wire wd_exp = (st_reg == FSW_EXPIRED);

   // ************************************************************
   // fault capture
   // ************************************************************
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         shd_in_d_reg <= 1'b1;
         ext_reg      <= 1'b0;
         wdf_reg      <= 1'b0;
         flt_reg      <= 1'b0;
      end else begin
         shd_in_d_reg <= shd_input;
         // only the on-to-off change counts, held low at enable is not a fault
         if (shd_enable && shd_in_d_reg && !shd_input)
            ext_reg <= 1'b1;
         if (wd_exp && act_reg == `FSW_ACT_SHD)
            wdf_reg <= 1'b1;
         // sticky, no software path clears it
         if ((shd_enable && shd_in_d_reg && !shd_input) ||
             (wd_exp && act_reg == `FSW_ACT_SHD))
            flt_reg <= 1'b1;
      end
   end

   wire force_safe = flt_reg && shd_enable;

   // ************************************************************
   // outputs
   // ************************************************************
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wd_flag        <= 1'b0;
         wd_ttl_out     <= 1'b0;
         halt           <= 1'b0;
         fault          <= 1'b0;
         ext_shd_seen   <= 1'b0;
         wd_expired_out <= 1'b0;
      end else begin
         wd_flag        <= wd_exp && act_reg == `FSW_ACT_IND;
         wd_ttl_out     <= wd_exp && act_reg == `FSW_ACT_TTL;
         halt           <= ext_reg && shd_enable;
         fault          <= flt_reg;
         ext_shd_seen   <= ext_reg;
         wd_expired_out <= wd_exp || wdf_reg;
      end
   end

   genvar i;
   generate
      for (i = 0; i < N_TTL; i++) begin : g_ttl
         always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
               ttl_out[i]  <= 1'b0;
               ttl_oe_n[i] <= 1'b1;
            end else if (force_safe) begin
               ttl_out[i]  <= (ttl_safe[2*i +: 2] == `FSW_SAFE_HIGH);
               ttl_oe_n[i] <= (ttl_safe[2*i +: 2] == `FSW_SAFE_HIZ) ||
                              (ttl_safe[2*i +: 2] == 2'h3);
            end else begin
               ttl_out[i]  <= ttl_norm[i];
               ttl_oe_n[i] <= ttl_norm_oe_n[i];
            end
         end
      end
      for (i = 0; i < N_ISO; i++) begin : g_iso
         always_ff @(posedge mclk or posedge rst) begin
            if (rst)
               iso_out[i] <= 1'b0;
            else
               iso_out[i] <= force_safe ? iso_safe[i] : iso_norm[i];
         end
      end
   endgenerate

   // ************************************************************
   // checks
   // ************************************************************
   property p_fault_sticky;
      @(posedge mclk) disable iff (rst) fault |=> fault;
   endproperty
   a_fault_sticky: assert property (p_fault_sticky) else $error("fault cleared");

   property p_ext_shd;
      @(posedge mclk) disable iff (rst)
         (shd_enable && $fell(shd_input)) |=> ##1 (fault && ext_shd_seen);
   endproperty
   a_ext_shd: assert property (p_ext_shd) else $error("shutdown not seen");

   property p_no_shd_disabled;
      @(posedge mclk) disable iff (rst)
         (!shd_enable && !flt_reg) |=> !ext_reg;
   endproperty
   a_no_shd_disabled: assert property (p_no_shd_disabled) else $error("fault while off");

   property p_iso_safe;
      @(posedge mclk) disable iff (rst)
         force_safe |=> (iso_out == $past(iso_safe));
   endproperty
   a_iso_safe: assert property (p_iso_safe) else $error("iso not safe");

   property p_iso_norm;
      @(posedge mclk) disable iff (rst)
         !force_safe |=> (iso_out == $past(iso_norm));
   endproperty
   a_iso_norm: assert property (p_iso_norm) else $error("iso changed");

   property p_flag_disarm;
      @(posedge mclk) disable iff (rst)
         (wd_exp && wd_disarm) |=> ##1 (!wd_flag && !wd_ttl_out);
   endproperty
   a_flag_disarm: assert property (p_flag_disarm) else $error("flag kept");

   // the output trails the state by a cycle, so a disarm one edge back also ends it
   property p_ttl_hold;
      @(posedge mclk) disable iff (rst)
         (wd_ttl_out && !wd_disarm && !$past(wd_disarm)) |=> wd_ttl_out;
   endproperty
   a_ttl_hold: assert property (p_ttl_hold) else $error("wd output dropped");

   property p_flag_only_ind;
      @(posedge mclk) disable iff (rst)
         wd_flag |-> !wd_ttl_out;
   endproperty
   a_flag_only_ind: assert property (p_flag_only_ind) else $error("two actions");

   property p_disarm_keeps;
      @(posedge mclk) disable iff (rst)
         (ext_reg && wd_disarm) |=> ext_reg;
   endproperty
   a_disarm_keeps: assert property (p_disarm_keeps) else $error("disarm cleared");

   property p_service;
      @(posedge mclk) disable iff (rst)
         (st_reg == FSW_ARMED && wd_service && !wd_disarm) |=> (ms_reg == 16'h0000);
   endproperty
   a_service: assert property (p_service) else $error("service ignored");
endmodule

// ---- inc/fsw_defs.svh ----
`ifndef FSW_DEFS_SVH
`define FSW_DEFS_SVH
`define FSW_CLK_HZ       25000000
`define FSW_TICK_MS      1
`define FSW_TICK_CYCLES  ((`FSW_CLK_HZ / 1000) * `FSW_TICK_MS)
`define FSW_TIMEOUT_MAX  16'hFFFE
`define FSW_ACT_IND      2'h0
`define FSW_ACT_TTL      2'h1
`define FSW_ACT_SHD      2'h2
`define FSW_SAFE_LOW     2'h0
`define FSW_SAFE_HIGH    2'h1
`define FSW_SAFE_HIZ     2'h2
`endif

// ---- inc/fsw_pkg.sv ----
package fsw_pkg;
   typedef logic [1:0] fsw_act_t;
   typedef logic [1:0] fsw_safe_t;
   typedef enum logic [2:0] {
      FSW_IDLE    = 3'b001,
      FSW_ARMED   = 3'b010,
      FSW_EXPIRED = 3'b100
   } fsw_wd_e;
endpackage

// ---- inc/fsw_tick_if.sv ----
`timescale 1ns/10ps
interface fsw_tick_if;
   logic tick;
   logic clr;
   modport src (input clr, output tick);
   modport dst (input tick, output clr);
endinterface

// ---- rtl/fsw_tick.sv ----
`timescale 1ns/10ps
`include "fsw_defs.svh"
module fsw_tick #(
   parameter int TICK_CYCLES = `FSW_TICK_CYCLES
) (
   input  wire logic mclk,
   input  wire logic rst,
   fsw_tick_if.src   tk
);
   logic [31:0] cnt_reg;
   logic        tick_reg;
   assign tk.tick = tick_reg;

   // restart on clear so a service yields a full first millisecond
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cnt_reg  <= 32'h0000_0000;
         tick_reg <= 1'b0;
      end else if (tk.clr) begin
         cnt_reg  <= 32'h0000_0000;
         tick_reg <= 1'b0;
      end else if (cnt_reg == 32'(TICK_CYCLES - 1)) begin
         cnt_reg  <= 32'h0000_0000;
         tick_reg <= 1'b1;
      end else begin
         cnt_reg  <= cnt_reg + 32'h0000_0001;
         tick_reg <= 1'b0;
      end
   end
endmodule

// ---- testbench/fsw_shd_src.sv ----
`timescale 1ns/10ps
// ****************************************
// external shutdown equipment
// ****************************************
module fsw_shd_src (
   input  wire logic mclk,
   input  wire logic go_off,
   output logic      shd_line
);
   initial shd_line = 1'b1;
   // line held on during normal running, dropped only on command
   always @(posedge mclk) begin
      shd_line <= ~go_off;
   end
endmodule

// ---- testbench/fsw_top_tb_top.sv ----
`timescale 1ns/10ps
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin miscompares++; \
   $display("[ERR] %s exp %h got %h", n, e, a); end end
module fsw_top_tb_top;
   import fsw_pkg::*;
   logic        mclk, rst, shd_enable, shd_input, wd_arm, wd_disarm, wd_service, go_off;
   logic [15:0] wd_timeout;
   logic [1:0]  wd_action;
   logic [17:0] ttl_safe;
   logic [8:0]  ttl_norm, ttl_norm_oe_n, ttl_out, ttl_oe_n;
   logic [3:0]  iso_safe, iso_norm, iso_out;
   logic        wd_flag, wd_ttl_out, halt, fault, ext_shd_seen, wd_expired_out;
   int          miscompares = 0;
   int          n_compared = 0;
   int          cycles = 0;
   // ****************************************
   // clock, partner and design
   // ****************************************
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   fsw_shd_src part (.mclk(mclk), .go_off(go_off), .shd_line(shd_input));
   // short prescaler keeps each millisecond at four cycles
   fsw_top #(.N_TTL(9), .N_ISO(4), .TICK_CYCLES(4)) uut (
      .mclk(mclk), .rst(rst), .shd_enable(shd_enable), .shd_input(shd_input),
      .wd_arm(wd_arm), .wd_disarm(wd_disarm), .wd_service(wd_service),
      .wd_timeout(wd_timeout), .wd_action(wd_action), .ttl_safe(ttl_safe),
      .iso_safe(iso_safe), .ttl_norm(ttl_norm), .ttl_norm_oe_n(ttl_norm_oe_n),
      .iso_norm(iso_norm), .ttl_out(ttl_out), .ttl_oe_n(ttl_oe_n), .iso_out(iso_out),
      .wd_flag(wd_flag), .wd_ttl_out(wd_ttl_out), .halt(halt), .fault(fault),
      .ext_shd_seen(ext_shd_seen), .wd_expired_out(wd_expired_out));
   // ****************************************
   // helpers
   // ****************************************
   task close_out;
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         close_out();
      end
   end
   // faults only clear on power cycle, so every test starts from reset
   task do_reset;
      @(negedge mclk);
      {rst, shd_enable, go_off, wd_arm, wd_disarm, wd_service} = 6'b100000;
      repeat (4) @(negedge mclk);
      rst = 1'b0;
   endtask
   task pulse(input int k);
      @(negedge mclk);
      case (k)
         0: wd_arm = 1'b1;
         1: wd_disarm = 1'b1;
         default: wd_service = 1'b1;
      endcase
      @(negedge mclk);
      {wd_arm, wd_disarm, wd_service} = 3'b000;
   endtask
   task wait_ind(input int n);
      for (int i = 0; i < n && !(fault === 1'b1 || wd_flag === 1'b1 || wd_ttl_out === 1'b1);
           i++) @(negedge mclk);
      @(negedge mclk);
   endtask
   // safe codes per output: 0 low, 1 high, 2 and 3 hi-z
   task chk_safe(input bit safe);
      if (safe) begin
         `CHK("ttl_oe_n", 9'h0cc, ttl_oe_n)
         `CHK("ttl_out", 9'h022, ttl_out & ~9'h0cc)
         `CHK("iso_out", 4'h5, iso_out)
      end else begin
         `CHK("ttl_oe_n norm", 9'h000, ttl_oe_n)
         `CHK("ttl_out norm", 9'h0f0, ttl_out)
         `CHK("iso_out norm", 4'ha, iso_out)
      end
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task t_ind;
      do_reset();
      wd_action = 2'h0;
      wd_timeout = 16'h0004;
      pulse(0);
      repeat (8) @(negedge mclk);
      `CHK("wd_flag early", 1'b0, wd_flag)
      pulse(2);
      repeat (8) @(negedge mclk);
      `CHK("wd_flag serviced", 1'b0, wd_flag)
      wait_ind(40);
      `CHK("wd_flag", 1'b1, wd_flag)
      `CHK("wd_ttl_out", 1'b0, wd_ttl_out)
      `CHK("wd_expired_out set", 1'b1, wd_expired_out)
      repeat (10) @(negedge mclk);
      `CHK("wd_flag held", 1'b1, wd_flag)
      pulse(1);
      @(negedge mclk);
      `CHK("wd_flag disarmed", 1'b0, wd_flag)
      repeat (40) @(negedge mclk);
      `CHK("wd_expired_out", 1'b0, wd_expired_out)
      $display("test indicator done");
   endtask
   task t_ttl;
      do_reset();
      wd_action = 2'h1;
      wd_timeout = 16'h0002;
      pulse(0);
      `CHK("wd_ttl_out low", 1'b0, wd_ttl_out)
      wait_ind(40);
      `CHK("wd_ttl_out high", 1'b1, wd_ttl_out)
      `CHK("wd_flag", 1'b0, wd_flag)
      pulse(2);
      repeat (20) @(negedge mclk);
      `CHK("wd_ttl_out held", 1'b1, wd_ttl_out)
      pulse(1);
      @(negedge mclk);
      `CHK("wd_ttl_out disarmed", 1'b0, wd_ttl_out)
      $display("test ttl action done");
   endtask
   task t_wd_shd;
      do_reset();
      shd_enable = 1'b1;
      wd_action = 2'h2;
      wd_timeout = 16'h0001;
      pulse(0);
      chk_safe(1'b0);
      wait_ind(40);
      `CHK("fault", 1'b1, fault)
      `CHK("ext_shd_seen", 1'b0, ext_shd_seen)
      `CHK("halt wd", 1'b0, halt)
      chk_safe(1'b1);
      pulse(1);
      repeat (3) @(negedge mclk);
      `CHK("fault sticky", 1'b1, fault)
      `CHK("wd_expired_out kept", 1'b1, wd_expired_out)
      $display("test watchdog shutdown done");
   endtask
   task t_ext;
      do_reset();
      shd_enable = 1'b1;
      repeat (4) @(negedge mclk);
      `CHK("fault idle", 1'b0, fault)
      go_off = 1'b1;
      wait_ind(20);
      `CHK("fault", 1'b1, fault)
      `CHK("halt", 1'b1, halt)
      `CHK("ext_shd_seen", 1'b1, ext_shd_seen)
      chk_safe(1'b1);
      go_off = 1'b0;
      pulse(1);
      repeat (4) @(negedge mclk);
      `CHK("fault sticky", 1'b1, fault)
      `CHK("ext_shd_seen kept", 1'b1, ext_shd_seen)
      $display("test external shutdown done");
   endtask
   task t_off;
      do_reset();
      go_off = 1'b1;
      wd_action = 2'h2;
      wd_timeout = 16'h0001;
      pulse(0);
      repeat (30) @(negedge mclk);
      `CHK("ext_shd_seen", 1'b0, ext_shd_seen)
      `CHK("halt", 1'b0, halt)
      chk_safe(1'b0);
      $display("test shutdown disabled done");
   endtask
   initial begin
      {rst, shd_enable, go_off, wd_arm, wd_disarm, wd_service} = 6'b100000;
      wd_timeout = 16'h0001;
      wd_action = 2'h0;
      for (int i = 0; i < 9; i++) ttl_safe[2*i +: 2] = 2'(i % 4);
      iso_safe = 4'h5;
      iso_norm = 4'ha;
      ttl_norm = 9'h0f0;
      ttl_norm_oe_n = 9'h000;
      t_ind();
      t_ttl();
      t_wd_shd();
      t_ext();
      t_off();
      close_out();
   end
endmodule
